//--- bench/pcv_core_sva.sv
`timescale 1ns/1ps
// Port checks of the program counter block
module pcv_core_sva
   import pcv_pkg::*;
(
   // Clock and controls
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic step_en,
   input wire logic branch_en,
   input wire logic [20:0] branch_target,
   input wire logic irq_ack,
   input wire logic wake_irq,
   input wire logic irq_is_high,
   input wire logic high_prio_global_irq_enable,
   input wire logic low_prio_global_irq_enable,
   input wire logic s_bvalid,
   // Fetch and stack state
   input wire logic [20:0] fetch_addr,
   input wire logic [15:0] fetch_rdata,
   input wire logic [15:0] instr_word,
   input wire logic [4:0] return_stack_pointer,
   input wire logic [20:0] stack_top
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Wake-up vectors only while a global enable is set
   wire wake_go = wake_irq && (high_prio_global_irq_enable || low_prio_global_irq_enable);
   wire vec_go = clk_en && (irq_ack || wake_go);
   wire quiet = !irq_ack && !wake_go;
   wire [20:0] vec_exp = irq_is_high ? VEC_HIGH : VEC_LOW;
   // A vector that still has room to push
   sequence push_s;
      vec_go && return_stack_pointer != SP_MAX;
   endsequence
   reset_load_a: assert property (disable iff (1'h0)
      rst |=> fetch_addr == VEC_RESET) else $error("reset vector missed");
   vector_load_a: assert property (
      vec_go |=> fetch_addr == $past(vec_exp)) else $error("vector address wrong");
   branch_load_a: assert property (
      clk_en && branch_en && quiet |=> fetch_addr == {$past(branch_target[20:1]), 1'h0})
      else $error("branch target not loaded");
   step_add_a: assert property (
      clk_en && step_en && !branch_en && quiet |=>
      fetch_addr == $past(fetch_addr) + PC_STEP || $rose(s_bvalid)) else $error("bad step");
   hold_a: assert property (
      !clk_en |=> $stable(fetch_addr)) else $error("pc moved while frozen");
   align_a: assert property (
      fetch_addr[0] == 1'h0) else $error("pc bit zero set");
   // The edge that releases reset still clears the word, so it starts no attempt
   blank_a: assert property (
      !rst && clk_en && fetch_addr > PROG_TOP |=> instr_word == 16'h0000)
      else $error("not blanked");
   fetch_word_a: assert property (
      !rst && clk_en && fetch_addr <= PROG_TOP |=> instr_word == $past(fetch_rdata))
      else $error("fetched word wrong");
   push_ptr_a: assert property (
      push_s |=> return_stack_pointer == $past(return_stack_pointer) + SP_ONE)
      else $error("pointer not advanced");
   push_tos_a: assert property (
      push_s ##1 clk_en |=> stack_top == $past(fetch_addr, 2)) else $error("pushed pc wrong");
endmodule

bind pcv_core pcv_core_sva u_sva (.*);

//--- bench/pcv_prog_mem.sv
`timescale 1ns/1ps
// Program memory model: combinational, answers in the fetch cycle
module pcv_prog_mem
   import pcv_pkg::*;
(
   // Fetch side
   input wire logic [20:0] fetch_addr,
   output logic [15:0] fetch_rdata
);
   // Past the implemented top it still drives a live pattern, so only the
   // core's own blanking can make those words read as zero
   assign fetch_rdata = fetch_addr[15:0] ^ 16'h5a5a;
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the program counter block
module tb_top;
   import pcv_pkg::*;
   // One row: controls for one cycle, branch target, expected address
   typedef struct {logic [7:0] c; logic [20:0] tgt; logic [20:0] exp;} pcv_row_s;
   logic clock = 1'h0, rst = 1'h1;
   logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0, s_rdata;
   logic [3:0] s_wstrb = 4'hf;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic clk_en, step_en, branch_en, irq_ack, wake_irq, irq_is_high;
   logic high_prio_global_irq_enable, low_prio_global_irq_enable;
   logic [7:0] ctl = 8'h80;
   logic [20:0] branch_target = 21'h0, fetch_addr, stack_top;
   logic [15:0] fetch_rdata, instr_word;
   logic [4:0] return_stack_pointer, sp_exp = 5'h00;
   int n_mismatch = 0, samples_checked = 0;
   // Controls travel packed so a row sets them all in one step
   assign {clk_en, step_en, branch_en, irq_ack, wake_irq, irq_is_high,
      high_prio_global_irq_enable, low_prio_global_irq_enable} = ctl;
   pcv_row_s rows [12] = '{'{8'ha0, 21'h001234, 21'h001234}, '{8'ha0, 21'h00abcd, 21'h00abcc},
      '{8'hc0, 21'h0, 21'h00abce}, '{8'h40, 21'h0, 21'h00abce}, '{8'h94, 21'h0, 21'h000008},
      '{8'h90, 21'h0, 21'h000018}, '{8'h8e, 21'h0, 21'h000008}, '{8'h89, 21'h0, 21'h000018},
      '{8'h8c, 21'h0, 21'h000018}, '{8'hb4, 21'h000100, 21'h000008},
      '{8'he0, 21'h01fffe, 21'h01fffe}, '{8'hc0, 21'h0, 21'h020000}};
   pcv_core uut (.*);
   pcv_prog_mem mem (.*);
   always #25 clock = ~clock;
   // Bench's own view of the fetched word, zero above the top
   function automatic logic [15:0] word_of(input logic [20:0] a);
      return (a > PROG_TOP) ? 16'h0 : a[15:0] ^ 16'h5a5a;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Address and data offered together, each dropped when taken
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      s_awvalid <= 1'h1;
      s_awaddr <= a;
      s_wvalid <= 1'h1;
      s_wdata <= d;
      s_bready <= 1'h1;
      // No cycle count assumed: only the watchdog ends a wait that never answers
      do begin
         @(posedge clock);
         if (s_awready && s_awvalid) s_awvalid <= 1'h0;
         if (s_wready && s_wvalid) s_wvalid <= 1'h0;
      end while (s_bvalid !== 1'h1);
      r = s_bresp;
      s_bready <= 1'h0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clock);
      s_arvalid <= 1'h1;
      s_araddr <= a;
      s_rready <= 1'h1;
      // Data and response are taken at the edge where rvalid is seen high
      do begin
         @(posedge clock);
         if (s_arready && s_arvalid) s_arvalid <= 1'h0;
      end while (s_rvalid !== 1'h1);
      chk(s_rdata, e, "read data");
      chk(32'(s_rresp), 32'(er), "read resp");
      s_rready <= 1'h0;
   endtask
   // Apply one row for a cycle, then look once both pipelines settled
   task automatic run_row(input pcv_row_s w);
      logic [20:0] prev;
      logic push;
      prev = fetch_addr;
      // A full stack still vectors but takes no push
      push = w.c[7] && (w.c[4] || (w.c[3] && (w.c[1] || w.c[0]))) && (sp_exp != SP_MAX);
      @(posedge clock);
      ctl <= w.c;
      branch_target <= w.tgt;
      @(posedge clock);
      ctl <= 8'h80;
      @(posedge clock);
      #1;
      sp_exp = sp_exp + {4'h0, push};
      chk(32'(fetch_addr), 32'(w.exp), "address");
      chk(32'(instr_word), 32'(word_of(w.exp)), "word");
      chk(32'(return_stack_pointer), 32'(sp_exp), "pointer");
      if (push) chk(32'(stack_top), 32'(prev), "stack top");
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog well past the expected run length
   initial begin
      #(50 * 20000);
      n_mismatch++;
      close_out;
   end
   initial begin
      logic [1:0] r;
      repeat (20) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
      #1;
      chk(32'(fetch_addr), 32'h0, "reset pc");
      rchk(OFS_HIGH_LATCH, 32'h0, RESP_OKAY);
      foreach (rows[i]) run_row(rows[i]);
      bus_wr(OFS_HIGH_LATCH, 32'h12, r);
      chk(32'(r), 32'(RESP_OKAY), "high latch write resp");
      bus_wr(OFS_UPPER_LATCH, 32'h03, r);
      chk(32'(r), 32'(RESP_OKAY), "upper latch write resp");
      chk(32'(fetch_addr), 32'h020000, "latch write moved pc");
      rchk(OFS_UPPER_LATCH, 32'h03, RESP_OKAY);
      bus_wr(OFS_PC_LOW, 32'h57, r);
      chk(32'(r), 32'(RESP_OKAY), "low write resp");
      #1;
      chk(32'(fetch_addr), 32'h031256, "low write");
      run_row('{8'ha0, 21'h0a5c40, 21'h0a5c40});
      rchk(OFS_HIGH_LATCH, 32'h12, RESP_OKAY);
      rchk(OFS_PC_LOW, 32'h40, RESP_OKAY);
      rchk(OFS_HIGH_LATCH, 32'h5c, RESP_OKAY);
      rchk(OFS_UPPER_LATCH, 32'h0a, RESP_OKAY);
      // A write without the low byte lane is answered but changes nothing
      s_wstrb <= 4'he;
      bus_wr(OFS_HIGH_LATCH, 32'hff, r);
      s_wstrb <= 4'hf;
      chk(32'(r), 32'(RESP_OKAY), "masked write resp");
      rchk(OFS_HIGH_LATCH, 32'h5c, RESP_OKAY);
      bus_wr(OFS_STACK_PTR, 32'h1, r);
      chk(32'(r), 32'(RESP_SLVERR), "read-only write");
      rchk(OFS_STACK_PTR, 32'(sp_exp), RESP_OKAY);
      // Fill the stack; the last vector finds it full and must not push
      repeat (27) run_row('{8'h94, 21'h0, 21'h000008});
      rchk(OFS_STACK_PTR, 32'h1f, RESP_OKAY);
      rchk(OFS_STACK_TOP, 32'h000008, RESP_OKAY);
      rchk(8'h14, 32'h0, RESP_SLVERR);
      @(posedge clock);
      rst <= 1'h1;
      repeat (2) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
      #1;
      chk(32'(fetch_addr), 32'h0, "pc after reset");
      chk(32'(return_stack_pointer), 32'h0, "pointer after reset");
      rchk(OFS_STACK_TOP, 32'h0, RESP_OKAY);
      close_out;
   end
endmodule

//--- rtl/pcv_core.sv
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Program counter, vectoring and fetch address logic
module pcv_core
   import pcv_pkg::*;
(
   // Clock, reset and enable
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // Register bus write address
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [7:0] s_awaddr,
   // Register bus write data
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   // Register bus write response
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   // Register bus read address
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [7:0] s_araddr,
   // Register bus read data
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   // Core sequencing controls
   input wire logic step_en,
   input wire logic branch_en,
   input wire logic [20:0] branch_target,
   // Interrupt acknowledge and wake-up
   input wire logic irq_ack,
   input wire logic wake_irq,
   input wire logic irq_is_high,
   input wire logic high_prio_global_irq_enable,
   input wire logic low_prio_global_irq_enable,
   // Instruction fetch bus
   output logic [20:0] fetch_addr,
   input wire logic [15:0] fetch_rdata,
   output logic [15:0] instr_word,
   // Stack state for the core
   output logic [4:0] return_stack_pointer,
   output logic [20:0] stack_top
);
   // Map a bus byte address onto a register select
   function automatic logic [2:0] reg_sel(input logic [7:0] addr);
      case (addr)
         OFS_PC_LOW: reg_sel = SEL_PC_LOW;
         OFS_HIGH_LATCH: reg_sel = SEL_HIGH;
         OFS_UPPER_LATCH: reg_sel = SEL_UPPER;
         OFS_STACK_PTR: reg_sel = SEL_SP;
         OFS_STACK_TOP: reg_sel = SEL_TOS;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   // Counter and latch state
   logic [20:0] pc_reg; // Whole program counter
   logic [20:0] pc_next;
   logic [7:0] pc_high_latch_reg; // Staging for middle byte
   logic [7:0] pc_high_latch_next;
   logic [4:0] pc_upper_latch_reg; // Staging for top byte
   logic [4:0] pc_upper_latch_next;
   logic [4:0] sp_reg; // Return stack pointer
   logic [4:0] sp_next;
   logic [15:0] instr_reg; // Fetched word

   // Bus handshake state
   logic aw_rdy_reg; // Address slot free
   logic w_rdy_reg; // Data slot free
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic ar_rdy_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // Views of the counter bytes
   wire [7:0] pc_low_byte = pc_reg[MID_LSB-1:0];
   wire [7:0] pc_middle_byte = pc_reg[TOP_LSB-1:MID_LSB];
   wire [4:0] pc_top_byte = pc_reg[PC_W-1:TOP_LSB];

   // Write path decoding
   wire aw_take = s_awvalid && aw_rdy_reg;
   wire w_take = s_wvalid && w_rdy_reg;
   wire aw_have = !aw_rdy_reg && !bvalid_reg;
   wire w_have = !w_rdy_reg && !bvalid_reg;
   // A write is done once both halves are held
   wire do_write = aw_have && w_have;
   wire [2:0] wr_sel = reg_sel(aw_addr_reg);
   wire wr_lane0 = w_strb_reg[0];
   wire wr_pcl = do_write && wr_lane0 && (wr_sel == SEL_PC_LOW);
   wire wr_high = do_write && wr_lane0 && (wr_sel == SEL_HIGH);
   wire wr_upper = do_write && wr_lane0 && (wr_sel == SEL_UPPER);
   wire wr_bad = (wr_sel == SEL_NONE);

   // Read path decoding
   wire ar_take = s_arvalid && ar_rdy_reg;
   wire [2:0] rd_sel = reg_sel(s_araddr);
   wire rd_pcl = ar_take && (rd_sel == SEL_PC_LOW);

   // Interrupt entry: acknowledge, or wake-up with a global enable set
   wire gie_any = high_prio_global_irq_enable || low_prio_global_irq_enable;
   wire vector_take = irq_ack || (wake_irq && gie_any);
   wire [20:0] irq_vector = irq_is_high ? VEC_HIGH : VEC_LOW;

   // Push target: pointer moves first, then PC lands there
   wire sp_full = (sp_reg == SP_MAX);
   wire [4:0] push_ptr = sp_reg + SP_ONE;
   wire push_en = vector_take && !sp_full;

   // Counter assembled from the latches on a low byte write
   wire [7:0] wr_low = {w_data_reg[MID_LSB-1:1], 1'b0};
   wire [20:0] pc_from_latch = {pc_upper_latch_reg, pc_high_latch_reg, wr_low};

   // Branch target kept word aligned
   wire [20:0] branch_aligned = {branch_target[PC_W-1:1], 1'b0};

   // Fetch above the implemented memory reads as zero, a no-op
   wire fetch_above = (pc_reg > PROG_TOP);

   // Next counter value by fixed priority
   always_comb begin
      pc_next = pc_reg;
      if (vector_take) begin
         pc_next = irq_vector;
      end else if (branch_en) begin
         pc_next = branch_aligned;
      end else if (wr_pcl) begin
         pc_next = pc_from_latch;
      end else if (step_en) begin
         pc_next = pc_reg + PC_STEP;
      end
   end

   // Latch next values; a low byte read outranks a latch write
   always_comb begin
      pc_high_latch_next = pc_high_latch_reg;
      pc_upper_latch_next = pc_upper_latch_reg;
      if (rd_pcl) begin
         pc_high_latch_next = pc_middle_byte;
         pc_upper_latch_next = pc_top_byte;
      end else begin
         if (wr_high) begin
            pc_high_latch_next = w_data_reg[BYTE_W-1:0];
         end
         if (wr_upper) begin
            pc_upper_latch_next = w_data_reg[TOP_W-1:0];
         end
      end
   end

   // Stack pointer stays at its top once full, no overwrite
   always_comb begin
      sp_next = sp_reg;
      if (push_en) begin
         sp_next = push_ptr;
      end
   end

   // Counter, latches and pointer; reset forces the reset vector
   always_ff @(posedge clock) begin
      if (rst) begin
         pc_reg <= VEC_RESET;
         pc_high_latch_reg <= LATCH_RESET;
         pc_upper_latch_reg <= LATCH_RESET[TOP_W-1:0];
         sp_reg <= SP_RESET;
      end else if (clk_en) begin
         pc_reg <= pc_next;
         pc_high_latch_reg <= pc_high_latch_next;
         pc_upper_latch_reg <= pc_upper_latch_next;
         sp_reg <= sp_next;
      end
   end

   // Fetched word on its own bus, zeroed above the top
   always_ff @(posedge clock) begin
      if (rst) begin
         instr_reg <= {WORD_W{1'b0}};
      end else if (clk_en) begin
         instr_reg <= fetch_above ? {WORD_W{1'b0}} : fetch_rdata;
      end
   end

   // Stack storage; read follows the live pointer
   pcv_stack_mem u_stack (
      .clock(clock),
      .clk_en(clk_en),
      .rst(rst),
      .wr_en(push_en),
      .wr_addr(push_ptr),
      .wr_data(pc_reg),
      .rd_addr(sp_reg),
      .rd_data(stack_top)
   );

   // Write address and data slots, taken in either order
   always_ff @(posedge clock) begin
      if (rst) begin
         aw_rdy_reg <= 1'b1;
         w_rdy_reg <= 1'b1;
         aw_addr_reg <= OFS_PC_LOW;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else if (clk_en) begin
         // Capture address
         if (aw_take) begin
            aw_rdy_reg <= 1'b0;
            aw_addr_reg <= s_awaddr;
         end
         // Capture data
         if (w_take) begin
            w_rdy_reg <= 1'b0;
            w_data_reg <= s_wdata;
            w_strb_reg <= s_wstrb;
         end
         // Slots reopen only after the response is taken
         if (bvalid_reg && s_bready) begin
            aw_rdy_reg <= 1'b1;
            w_rdy_reg <= 1'b1;
         end
      end
   end

   // Write response, error for unmapped or read-only offsets
   always_ff @(posedge clock) begin
      if (rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (clk_en) begin
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_bad || wr_sel == SEL_SP || wr_sel == SEL_TOS) ?
               RESP_SLVERR : RESP_OKAY;
         end else if (s_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Read data selection; middle and top bytes have no window
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h00000000;
      case (rd_sel)
         SEL_PC_LOW: rd_word[BYTE_W-1:0] = pc_low_byte;
         SEL_HIGH: rd_word[BYTE_W-1:0] = pc_high_latch_reg;
         SEL_UPPER: rd_word[TOP_W-1:0] = pc_upper_latch_reg;
         SEL_SP: rd_word[SP_W-1:0] = sp_reg;
         SEL_TOS: rd_word[PC_W-1:0] = stack_top;
         default: rd_word = 32'h00000000;
      endcase
   end

   // Read channel, one read in flight
   always_ff @(posedge clock) begin
      if (rst) begin
         ar_rdy_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= RESP_OKAY;
      end else if (clk_en) begin
         if (ar_take) begin
            ar_rdy_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (rvalid_reg && s_rready) begin
            rvalid_reg <= 1'b0;
            ar_rdy_reg <= 1'b1;
         end
      end
   end

   // Outputs straight from registers
   assign s_awready = aw_rdy_reg;
   assign s_wready = w_rdy_reg;
   assign s_bvalid = bvalid_reg;
   assign s_bresp = bresp_reg;
   assign s_arready = ar_rdy_reg;
   assign s_rvalid = rvalid_reg;
   assign s_rdata = rdata_reg;
   assign s_rresp = rresp_reg;
   assign fetch_addr = pc_reg;
   assign instr_word = instr_reg;
   assign return_stack_pointer = sp_reg;
endmodule

//--- rtl/pcv_stack_mem.sv
`timescale 1ns/1ps
// Return stack storage, location zero is never written and reads as zero
module pcv_stack_mem
   import pcv_pkg::*;
(
   // Clocking
   input wire logic clock,
   input wire logic clk_en,
   input wire logic rst,
   // Write port
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [20:0] wr_data,
   // Read port, data one cycle later
   input wire logic [4:0] rd_addr,
   output logic [20:0] rd_data
);
   // Storage, no reset: contents are undefined until pushed
   logic [20:0] mem_reg [0:31];
   logic [20:0] rd_data_reg;
   // Location zero is never written, so pointer zero must not read the unwritten word
   wire rd_empty = (rd_addr == SP_RESET);

   // Write port, stores on a push
   always_ff @(posedge clock) begin
      if (clk_en && wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   // Read data register, cleared by reset
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_data_reg <= VEC_RESET;
      end else if (clk_en) begin
         rd_data_reg <= rd_empty ? VEC_RESET : mem_reg[rd_addr];
      end
   end

   assign rd_data = rd_data_reg;
endmodule

//--- shared/pcv_pkg.sv
// What this block does
// - Program counter is 21-bit byte address
// - Fetch above implemented memory returns zeros
// - Any reset loads reset vector zero
// - Interrupt loads 0008h high, 0018h low
// - Software reads and writes low byte
// - Middle byte changes only via high latch
// - Top byte changes only via upper latch
// - Low byte write copies latches into PC
// - Low byte read copies PC into latches
// - Low byte bit zero always reads zero
// - Sequential step adds two per instruction
// - Branches load PC, latches left untouched
// - Interrupt wake-up pushes PC onto stack unless the stack is full
// - Interrupt wake-up then loads matching vector
// - Fetch uses bus separate from data
// - Push increments pointer, then stores PC
package pcv_pkg;
   // Address and field widths
   localparam int PC_W = 21;
   localparam int MID_LSB = 8;
   localparam int TOP_LSB = 16;
   localparam int TOP_W = 5;
   localparam int BYTE_W = 8;
   localparam int SP_W = 5;
   localparam int WORD_W = 16;
   // Fixed vectors and step
   localparam logic [20:0] VEC_RESET = 21'h000000;
   localparam logic [20:0] VEC_HIGH = 21'h000008;
   localparam logic [20:0] VEC_LOW = 21'h000018;
   localparam logic [20:0] PC_STEP = 21'h000002;
   // Top of the physically implemented program memory
   localparam logic [20:0] PROG_TOP = 21'h01ffff;
   // Stack pointer limits
   localparam logic [4:0] SP_RESET = 5'h00;
   localparam logic [4:0] SP_MAX = 5'h1f;
   localparam logic [4:0] SP_ONE = 5'h01;
   // Register byte offsets on the bus
   localparam logic [7:0] OFS_PC_LOW = 8'h00;
   localparam logic [7:0] OFS_HIGH_LATCH = 8'h04;
   localparam logic [7:0] OFS_UPPER_LATCH = 8'h08;
   localparam logic [7:0] OFS_STACK_PTR = 8'h0c;
   localparam logic [7:0] OFS_STACK_TOP = 8'h10;
   // Decoded register selects
   localparam logic [2:0] SEL_NONE = 3'h0;
   localparam logic [2:0] SEL_PC_LOW = 3'h1;
   localparam logic [2:0] SEL_HIGH = 3'h2;
   localparam logic [2:0] SEL_UPPER = 3'h3;
   localparam logic [2:0] SEL_SP = 3'h4;
   localparam logic [2:0] SEL_TOS = 3'h5;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Reset value of the latch registers
   localparam logic [7:0] LATCH_RESET = 8'h00;
endpackage
